// ==== src/dcr_map.svh ====
`ifndef DCR_MAP_SVH
`define DCR_MAP_SVH
// Notes on behaviour
// - config bit 7 picks spread range: 0 is 20-50 MHz, 1 is 5-20 MHz.
// - strobe edge bit: 0 aligns data to falling clock edge, 1 to rising.
// - config field 3:2: 00 filter off, 01 filter on, 10/11 reserved.
// - sleep bit enters sleep keeping all registers; clearing it resumes normal work.
// - register-control 0 takes config from pins; 1 from registers except address.
// - address bit 7: 0 uses strap-decoded address, 1 uses the register field.
// - address field resets to 1110000; only 0x71, 0x72, 0x73, 0x76 valid.
// - hold-low bit 0 drives outputs low except lock and pass; 1 releases them.
// - hold-low control acts only while link is locked; ignored when unlocked.
// - in sleep, select bit drives outputs low (0) or high-z (1); pass high.
// - strap override 0 leaves hold-low to strap; 1 forces hold-low off while register-control is 1.
// - oscillator select 000 disables; 001..111 pick 50 down to 6.3 MHz.
// - top three bits of fourth register pick one of eight equalizer gain steps.
// - all four registers read and write; fields reset to defaults.
// - first register resets to 00h; writing 01h enables register configuration.
// - enabled control filter rejects short glitches on the control signals.
// - bus slave at one of four addresses; acks writes, host acks reads.

// register offsets
`define DCR_OFS_CONFIG 8'h00
`define DCR_OFS_ADDR 8'h01
`define DCR_OFS_FEAT 8'h02
`define DCR_OFS_EQSS 8'h03
// reset values
`define DCR_RST_CONFIG 8'h00
`define DCR_RST_ADDR 8'h70
`define DCR_RST_FEAT 8'h00
`define DCR_RST_EQSS 8'h00
// field positions
`define DCR_CFG_REGCTL 0
`define DCR_CFG_SLEEP 1
`define DCR_CFG_MODE_LO 2
`define DCR_CFG_MODE_HI 3
`define DCR_CFG_EDGE 4
`define DCR_CFG_SLEW_DATA 5
`define DCR_CFG_SLEW_CLK 6
`define DCR_CFG_LOWRANGE 7
`define DCR_ADDR_SRC 7
`define DCR_FEAT_OSC_HI 2
`define DCR_FEAT_OVR 3
`define DCR_FEAT_OSS 6
`define DCR_FEAT_HOLD 7
`define DCR_EQ_LO 5
// filter mode codes
`define DCR_MODE_FILT_OFF 2'h0
`define DCR_MODE_FILT_ON 2'h1
// valid bus addresses by strap code
`define DCR_BUS_ADDR0 7'h71
`define DCR_BUS_ADDR1 7'h72
`define DCR_BUS_ADDR2 7'h73
`define DCR_BUS_ADDR3 7'h76
// control filter: a level must stand this long before it passes
`define DCR_CLK_PERIOD_NS 10
`define DCR_FILT_TIME_NS 40
`define DCR_FILT_CYC ((`DCR_FILT_TIME_NS + `DCR_CLK_PERIOD_NS - 1) / `DCR_CLK_PERIOD_NS)
`endif

// ==== src/dcr_pkg.sv ====
package dcr_pkg;
	typedef enum logic [2:0] {
		DCR_IDLE,
		DCR_ADDR,
		DCR_ACK_ADDR,
		DCR_WRITE,
		DCR_ACK_WR,
		DCR_READ,
		DCR_ACK_RD
	} dcr_bus_state_e;
	typedef logic [7:0] dcr_byte_t;
endpackage

// ==== src/dcr_sync2.sv ====
`timescale 1ns/1ns
module dcr_sync2 import dcr_pkg::*; #(
	parameter int W = 1
) (
	input wire logic core_clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			meta_reg <= '0;
			q_out <= '0;
		end else if (ce_in) begin
			meta_reg <= d_in;
			q_out <= meta_reg;
		end
	end
endmodule

// ==== src/dcr_i2c_slave.sv ====
`timescale 1ns/1ns
module dcr_i2c_slave import dcr_pkg::*; (
	input wire logic core_clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic [6:0] own_addr_in,
	input wire dcr_byte_t rd_data_in,
	output logic sda_oe_out,
	output logic wr_en_out,
	output dcr_byte_t ptr_out,
	output dcr_byte_t wr_data_out
);
	// ----------------------------------------
	// pin sampling and bus conditions
	// ----------------------------------------
	logic scl_s, sda_s, scl_d_reg, sda_d_reg;
	dcr_sync2 #(.W(2)) u_sync (
		.core_clk_in(core_clk_in),
		.rstn_in(rstn_in),
		.ce_in(ce_in),
		.d_in({scl_in, sda_in}),
		.q_out({scl_s, sda_s})
	);
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			scl_d_reg <= 1'b0;
			sda_d_reg <= 1'b0;
		end else if (ce_in) begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end
	wire logic scl_rise = scl_s & ~scl_d_reg;
	wire logic scl_fall = ~scl_s & scl_d_reg;
	wire logic start_seen = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	wire logic stop_seen = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

	// ----------------------------------------
	// protocol engine
	// ----------------------------------------
	dcr_bus_state_e state_reg;
	dcr_byte_t shift_reg;
	logic [2:0] bit_reg;
	logic first_reg, read_reg, match_reg, nack_reg, got_reg;
	// byte arrives on the eighth rising clock edge
	wire logic byte_in = scl_rise & (bit_reg == 3'h7);
	wire dcr_byte_t byte_val = {shift_reg[6:0], sda_s};

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_reg <= DCR_IDLE;
			shift_reg <= 8'h00;
			bit_reg <= 3'h0;
			first_reg <= 1'b0;
			read_reg <= 1'b0;
			match_reg <= 1'b0;
			nack_reg <= 1'b0;
			got_reg <= 1'b0;
			sda_oe_out <= 1'b0;
			wr_en_out <= 1'b0;
			ptr_out <= 8'h00;
			wr_data_out <= 8'h00;
		end else if (ce_in) begin
			wr_en_out <= 1'b0;
			if (start_seen) begin
				// repeated start keeps the pointer for the read that follows
				state_reg <= DCR_ADDR;
				bit_reg <= 3'h0;
				got_reg <= 1'b0;
				sda_oe_out <= 1'b0;
			end else if (stop_seen) begin
				state_reg <= DCR_IDLE;
				sda_oe_out <= 1'b0;
			end else begin
				unique case (state_reg)
				DCR_IDLE: begin
				end
				DCR_ADDR: begin
					if (scl_rise) begin
						shift_reg <= byte_val;
						bit_reg <= bit_reg + 3'h1;
					end
					if (byte_in) begin
						got_reg <= 1'b1;
						match_reg <= (byte_val[7:1] == own_addr_in);
						read_reg <= byte_val[0];
					end
					// the clock fall that closes a start carries no byte yet
					if (scl_fall && got_reg) begin
						got_reg <= 1'b0;
						if (match_reg) begin
							state_reg <= DCR_ACK_ADDR;
							sda_oe_out <= 1'b1;
						end else begin
							state_reg <= DCR_IDLE;
						end
					end
				end
				DCR_ACK_ADDR: begin
					if (scl_fall) begin
						first_reg <= 1'b1;
						if (read_reg) begin
							state_reg <= DCR_READ;
							shift_reg <= rd_data_in;
							sda_oe_out <= ~rd_data_in[7];
						end else begin
							state_reg <= DCR_WRITE;
							sda_oe_out <= 1'b0;
						end
					end
				end
				DCR_WRITE: begin
					if (scl_rise) begin
						shift_reg <= byte_val;
						bit_reg <= bit_reg + 3'h1;
					end
					if (byte_in) begin
						if (first_reg) begin
							ptr_out <= byte_val;
						end else begin
							wr_en_out <= 1'b1;
							wr_data_out <= byte_val;
						end
					end
					if (scl_fall && bit_reg == 3'h0) begin
						state_reg <= DCR_ACK_WR;
						sda_oe_out <= 1'b1;
					end
				end
				DCR_ACK_WR: begin
					if (scl_fall) begin
						state_reg <= DCR_WRITE;
						sda_oe_out <= 1'b0;
						// pointer byte must not advance the pointer
						first_reg <= 1'b0;
					end
					if (scl_rise && !first_reg) begin
						ptr_out <= ptr_out + 8'h01;
					end
				end
				DCR_READ: begin
					if (scl_fall) begin
						if (bit_reg == 3'h7) begin
							state_reg <= DCR_ACK_RD;
							sda_oe_out <= 1'b0;
							bit_reg <= 3'h0;
							ptr_out <= ptr_out + 8'h01;
						end else begin
							shift_reg <= {shift_reg[6:0], 1'b0};
							sda_oe_out <= ~shift_reg[6];
							bit_reg <= bit_reg + 3'h1;
						end
					end
				end
				DCR_ACK_RD: begin
					if (scl_rise) begin
						nack_reg <= sda_s;
					end
					if (scl_fall) begin
						// host nack ends the read; wait for stop
						if (nack_reg) begin
							state_reg <= DCR_IDLE;
						end else begin
							state_reg <= DCR_READ;
							shift_reg <= rd_data_in;
							sda_oe_out <= ~rd_data_in[7];
						end
					end
				end
				endcase
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_ack_addr: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		state_reg == DCR_ACK_ADDR |-> sda_oe_out)
		else $error("address ack not driven");
	chk_write_ack: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		state_reg == DCR_ACK_WR |-> sda_oe_out)
		else $error("data ack not driven");
	cov_read: cover property (@(posedge core_clk_in) disable iff (!rstn_in) state_reg == DCR_ACK_RD);
endmodule

// ==== src/dcr_top.sv ====
`timescale 1ns/1ns
`include "dcr_map.svh"
module dcr_top import dcr_pkg::*; (
	input wire logic core_clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	input wire logic [1:0] address_strap_pin_in,
	input wire logic strap_strobe_edge_select_in,
	input wire logic strap_filter_in,
	input wire logic strap_low_range_in,
	input wire logic strap_output_hold_low_in,
	input wire logic link_locked_in,
	input wire logic pass_in,
	input wire logic clk_phase_in,
	input wire logic [23:0] data_in,
	input wire logic [2:0] ctrl_in,
	output logic recovered_clock_out,
	output logic [23:0] data_out,
	output logic control_out_first_out,
	output logic control_out_second_out,
	output logic control_out_third_out,
	output logic outputs_oe_out,
	output logic link_locked_out,
	output logic pass_out,
	output logic low_range_spread_select_out,
	output logic clock_out_slew_boost_out,
	output logic data_out_slew_boost_out,
	output logic [2:0] internal_oscillator_select_out,
	output logic [2:0] equalizer_gain_step_out,
	output logic [3:0] spread_clock_generator_out,
	output logic equalizer_enable_out
);
	// ----------------------------------------
	// strap and lock pins
	// ----------------------------------------
	logic [1:0] strap_id_s;
	logic strap_edge_s, strap_filt_s, strap_lr_s, strap_hold_s, lock_s, pass_s;
	dcr_sync2 #(.W(8)) u_pin_sync (
		.core_clk_in(core_clk_in),
		.rstn_in(rstn_in),
		.ce_in(ce_in),
		.d_in({address_strap_pin_in, strap_strobe_edge_select_in, strap_filter_in,
			strap_low_range_in, strap_output_hold_low_in, link_locked_in, pass_in}),
		.q_out({strap_id_s, strap_edge_s, strap_filt_s, strap_lr_s, strap_hold_s, lock_s, pass_s})
	);

	// ----------------------------------------
	// register bank
	// ----------------------------------------
	dcr_byte_t deserializer_config_reg, bus_address_control_reg;
	dcr_byte_t output_feature_control_reg, equalizer_spread_control_reg;
	dcr_byte_t ptr, wr_data, rd_data;
	logic wr_en;

	// reserved bits and reserved mode codes are stored as written and read back
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			deserializer_config_reg <= `DCR_RST_CONFIG;
			bus_address_control_reg <= `DCR_RST_ADDR;
			output_feature_control_reg <= `DCR_RST_FEAT;
			equalizer_spread_control_reg <= `DCR_RST_EQSS;
		end else if (ce_in && wr_en) begin
			unique case (ptr)
			`DCR_OFS_CONFIG: deserializer_config_reg <= wr_data;
			`DCR_OFS_ADDR: bus_address_control_reg <= wr_data;
			`DCR_OFS_FEAT: output_feature_control_reg <= wr_data;
			`DCR_OFS_EQSS: equalizer_spread_control_reg <= wr_data;
			default: begin
			end
			endcase
		end
	end

	always_comb begin
		unique case (ptr)
		`DCR_OFS_CONFIG: rd_data = deserializer_config_reg;
		`DCR_OFS_ADDR: rd_data = bus_address_control_reg;
		`DCR_OFS_FEAT: rd_data = output_feature_control_reg;
		`DCR_OFS_EQSS: rd_data = equalizer_spread_control_reg;
		default: rd_data = 8'h00;
		endcase
	end

	// ----------------------------------------
	// bus address and slave
	// ----------------------------------------
	logic [6:0] strap_addr, own_addr;
	always_comb begin
		unique case (strap_id_s)
		2'h0: strap_addr = `DCR_BUS_ADDR0;
		2'h1: strap_addr = `DCR_BUS_ADDR1;
		2'h2: strap_addr = `DCR_BUS_ADDR2;
		2'h3: strap_addr = `DCR_BUS_ADDR3;
		endcase
	end
	// address source ignores register-control on purpose
	assign own_addr = bus_address_control_reg[`DCR_ADDR_SRC] ? bus_address_control_reg[6:0] : strap_addr;

	logic slave_oe;
	dcr_i2c_slave u_slave (
		.core_clk_in(core_clk_in),
		.rstn_in(rstn_in),
		.ce_in(ce_in),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.own_addr_in(own_addr),
		.rd_data_in(rd_data),
		.sda_oe_out(slave_oe),
		.wr_en_out(wr_en),
		.ptr_out(ptr),
		.wr_data_out(wr_data)
	);
	// open drain: only ever pull low
	assign sda_oe_out = slave_oe;
	assign sda_out = 1'b0;

	// ----------------------------------------
	// effective configuration
	// ----------------------------------------
	wire logic reg_mode = deserializer_config_reg[`DCR_CFG_REGCTL];
	wire logic [1:0] mode_code = deserializer_config_reg[`DCR_CFG_MODE_HI:`DCR_CFG_MODE_LO];
	wire logic edge_eff = reg_mode ? deserializer_config_reg[`DCR_CFG_EDGE] : strap_edge_s;
	// reserved mode codes leave the filter off
	wire logic filt_eff = reg_mode ? (mode_code == `DCR_MODE_FILT_ON) : strap_filt_s;
	wire logic lr_eff = reg_mode ? deserializer_config_reg[`DCR_CFG_LOWRANGE] : strap_lr_s;
	wire logic sleep_eff = reg_mode & deserializer_config_reg[`DCR_CFG_SLEEP];
	wire logic sleep_output_state_select = output_feature_control_reg[`DCR_FEAT_OSS];
	wire logic hold_feat = ~(reg_mode & output_feature_control_reg[`DCR_FEAT_OVR]) & strap_hold_s;
	wire logic hold_eff = lock_s & hold_feat & ~output_feature_control_reg[`DCR_FEAT_HOLD];
	wire logic quiet = sleep_eff | hold_eff;

	// ----------------------------------------
	// control glitch filter
	// ----------------------------------------
	localparam logic [3:0] FILT_LAST = 4'(`DCR_FILT_CYC - 1);
	logic [2:0] ctrl_filt;
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_filt
			logic cand_reg, val_reg;
			logic [3:0] cnt_reg;
			// a level must hold for the full window, so real edges lag by that much
			always_ff @(posedge core_clk_in or negedge rstn_in) begin
				if (!rstn_in) begin
					cand_reg <= 1'b0;
					val_reg <= 1'b0;
					cnt_reg <= 4'h0;
				end else if (ce_in) begin
					if (ctrl_in[gi] != cand_reg) begin
						cand_reg <= ctrl_in[gi];
						cnt_reg <= 4'h0;
					end else if (cnt_reg != FILT_LAST) begin
						cnt_reg <= cnt_reg + 4'h1;
					end else begin
						val_reg <= cand_reg;
					end
				end
			end
			assign ctrl_filt[gi] = filt_eff ? val_reg : ctrl_in[gi];
		end
	endgenerate

	// ----------------------------------------
	// output stage
	// ----------------------------------------
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			data_out <= 24'h000000;
			control_out_first_out <= 1'b0;
			control_out_second_out <= 1'b0;
			control_out_third_out <= 1'b0;
			recovered_clock_out <= 1'b0;
		end else if (ce_in) begin
			data_out <= quiet ? 24'h000000 : data_in;
			control_out_first_out <= ~quiet & ctrl_filt[0];
			control_out_second_out <= ~quiet & ctrl_filt[1];
			control_out_third_out <= ~quiet & ctrl_filt[2];
			// falling-edge strobe inverts the clock so data settles on the opposite edge
			recovered_clock_out <= ~quiet & (clk_phase_in ^ ~edge_eff);
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			outputs_oe_out <= 1'b1;
			link_locked_out <= 1'b0;
			pass_out <= 1'b0;
		end else if (ce_in) begin
			outputs_oe_out <= ~(sleep_eff & sleep_output_state_select);
			link_locked_out <= lock_s;
			pass_out <= sleep_eff | pass_s;
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			low_range_spread_select_out <= 1'b0;
			clock_out_slew_boost_out <= 1'b0;
			data_out_slew_boost_out <= 1'b0;
			internal_oscillator_select_out <= 3'h0;
			equalizer_gain_step_out <= 3'h0;
			spread_clock_generator_out <= 4'h0;
			equalizer_enable_out <= 1'b0;
		end else if (ce_in) begin
			low_range_spread_select_out <= lr_eff;
			clock_out_slew_boost_out <= reg_mode & deserializer_config_reg[`DCR_CFG_SLEW_CLK];
			data_out_slew_boost_out <= reg_mode & deserializer_config_reg[`DCR_CFG_SLEW_DATA];
			internal_oscillator_select_out <= reg_mode ? output_feature_control_reg[`DCR_FEAT_OSC_HI:0] : 3'h0;
			equalizer_gain_step_out <= reg_mode ? equalizer_spread_control_reg[7:`DCR_EQ_LO] : 3'h0;
			spread_clock_generator_out <= reg_mode ? equalizer_spread_control_reg[3:0] : 4'h0;
			equalizer_enable_out <= reg_mode & equalizer_spread_control_reg[4];
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);

	chk_sleep_low: assert property (ce_in && sleep_eff |=> data_out == 24'h000000 && !recovered_clock_out)
		else $error("sleep did not quiet outputs");
	chk_sleep_tristate: assert property (ce_in && sleep_eff && sleep_output_state_select |=> !outputs_oe_out)
		else $error("sleep high-z not applied");
	chk_sleep_pass: assert property (ce_in && sleep_eff |=> pass_out)
		else $error("pass not high in sleep");
	chk_hold_low: assert property (ce_in && lock_s && hold_feat
		&& !output_feature_control_reg[`DCR_FEAT_HOLD] |=> data_out == 24'h000000 && link_locked_out)
		else $error("hold low not applied");
	chk_unlock_ignore: assert property (ce_in && !lock_s && !sleep_eff |=> data_out == $past(data_in))
		else $error("hold low acted while unlocked");
	chk_strap_override: assert property (ce_in && reg_mode && output_feature_control_reg[`DCR_FEAT_OVR]
		&& !sleep_eff |=> data_out == $past(data_in))
		else $error("override did not turn hold low off");
	chk_reg_write: assert property (ce_in && wr_en && ptr == `DCR_OFS_ADDR |=> bus_address_control_reg == $past(wr_data))
		else $error("register write lost");
	chk_addr_source: assert property (bus_address_control_reg[`DCR_ADDR_SRC] |-> own_addr == bus_address_control_reg[6:0])
		else $error("address source wrong");
	chk_edge_select: assert property (ce_in && !quiet |=> recovered_clock_out == ($past(clk_phase_in) ^ !$past(edge_eff)))
		else $error("strobe edge wrong");
	chk_equalizer_gain_step: assert property (ce_in && reg_mode |=> equalizer_gain_step_out == $past(equalizer_spread_control_reg[7:5]))
		else $error("equalizer step wrong");

	chk_sleep_ctrl: assert property (ce_in && sleep_eff
		|=> !control_out_first_out && !control_out_second_out && !control_out_third_out)
		else $error("sleep left control outputs up");
	chk_sleep_drive: assert property (ce_in && sleep_eff && !sleep_output_state_select |=> outputs_oe_out)
		else $error("sleep low state not driven");
	chk_wake_oe: assert property (ce_in && !sleep_eff |=> outputs_oe_out)
		else $error("outputs not driven when awake");
	chk_lock_follow: assert property (ce_in |=> link_locked_out == $past(lock_s))
		else $error("lock output not following lock");
	chk_pass_follow: assert property (ce_in && !sleep_eff |=> pass_out == $past(pass_s))
		else $error("pass output not following pass");
	chk_low_range: assert property (ce_in && reg_mode
		|=> low_range_spread_select_out == $past(deserializer_config_reg[`DCR_CFG_LOWRANGE]))
		else $error("spread range select wrong");
	chk_pin_edge: assert property (ce_in && !reg_mode && !quiet
		|=> recovered_clock_out == ($past(clk_phase_in) ^ !$past(strap_edge_s)))
		else $error("pin mode strobe edge wrong");
	chk_pin_forced: assert property (ce_in && !reg_mode
		|=> !clock_out_slew_boost_out && !data_out_slew_boost_out && internal_oscillator_select_out == 3'h0
		&& equalizer_gain_step_out == 3'h0)
		else $error("pin mode let register settings through");
	chk_osc_select: assert property (ce_in && reg_mode
		|=> internal_oscillator_select_out == $past(output_feature_control_reg[2:0]))
		else $error("oscillator select wrong");
	chk_filter_off: assert property (ce_in && !filt_eff && !quiet
		|=> control_out_first_out == $past(ctrl_in[0]))
		else $error("control passed filtered while filter off");
	chk_filter_glitch: assert property (ce_in && filt_eff && !quiet && ctrl_in[0] != g_filt[0].cand_reg
		##1 ce_in && filt_eff && !quiet
		|=> control_out_first_out == $past(control_out_first_out))
		else $error("filter passed a fresh change");
	chk_cfg_write: assert property (ce_in && wr_en && ptr == `DCR_OFS_CONFIG
		|=> deserializer_config_reg == $past(wr_data))
		else $error("config write lost");
	chk_feat_write: assert property (ce_in && wr_en && ptr == `DCR_OFS_FEAT
		|=> output_feature_control_reg == $past(wr_data))
		else $error("feature write lost");
	chk_eqss_write: assert property (ce_in && wr_en && ptr == `DCR_OFS_EQSS
		|=> equalizer_spread_control_reg == $past(wr_data))
		else $error("equalizer write lost");
	chk_hold_release: assert property (ce_in && !sleep_eff && output_feature_control_reg[`DCR_FEAT_HOLD]
		|=> data_out == $past(data_in))
		else $error("released outputs still held");
	chk_hold_pin: assert property (ce_in && !reg_mode && lock_s && strap_hold_s
		&& !output_feature_control_reg[`DCR_FEAT_HOLD] |=> data_out == 24'h000000)
		else $error("strap hold low not applied in pin mode");
	chk_hold_ctrl: assert property (ce_in && hold_eff
		|=> !control_out_first_out && !control_out_second_out && !control_out_third_out)
		else $error("hold low left control outputs up");
	chk_strap_addr: assert property (!bus_address_control_reg[`DCR_ADDR_SRC] && strap_id_s == 2'h3
		|-> own_addr == 7'h76)
		else $error("strap address wrong");
	chk_sleep_keeps: assert property (ce_in && sleep_eff && !wr_en
		|=> $stable(deserializer_config_reg) && $stable(output_feature_control_reg))
		else $error("sleep disturbed registers");

	cov_reg_mode: cover property ($rose(reg_mode));
	cov_sleep_hiz: cover property (sleep_eff && sleep_output_state_select);
	cov_hold: cover property (hold_eff ##1 !hold_eff);
	cov_filter: cover property (filt_eff && ctrl_in != ctrl_filt);
endmodule

// ==== tb/dcr_i2c_host.sv ====
`timescale 1ns/1ns
module dcr_i2c_host (
	input wire logic core_clk_in,
	input wire logic sda_oe_in,
	output logic scl_out,
	output logic sda_out
);
	logic drv;
	// ----------------------------------------
	// open-drain wire: pull-up unless a party pulls low
	// ----------------------------------------
	assign sda_out = drv & ~sda_oe_in;
	initial begin
		drv = 1'b1;
		scl_out = 1'b1;
	end
	// ----------------------------------------
	// bus phases: 5 core clocks each, above the 4-clock minimum
	// ----------------------------------------
	task automatic ph(input logic c, input logic d);
		scl_out = c;
		drv = d;
		repeat (5) @(negedge core_clk_in);
	endtask
	// outside start and stop, sda only moves while scl is low, so no false start or stop
	task automatic start;
		ph(1'b0, drv);
		ph(1'b0, 1'b1);
		ph(1'b1, 1'b1);
		ph(1'b1, 1'b0);
		ph(1'b0, 1'b0);
	endtask
	task automatic stop;
		ph(1'b0, drv);
		ph(1'b0, 1'b0);
		ph(1'b1, 1'b0);
		ph(1'b1, 1'b1);
	endtask
	task automatic bitx(input logic b, output logic r);
		ph(1'b0, drv);
		ph(1'b0, b);
		ph(1'b1, b);
		r = sda_out;
		ph(1'b1, b);
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(d[i], r);
		bitx(1'b1, r);
		ack = ~r;
	endtask
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
		bitx(last, r);
	endtask
endmodule

// ==== tb/dcr_top_tb.sv ====
`timescale 1ns/1ns
module dcr_top_tb import dcr_pkg::*; ;
	logic clk, rstn, scl, sda, sda_oe, s_edge, s_filt, s_lr, s_hold, lock, pass, phase, a;
	logic [1:0] strap;
	logic [23:0] din, dout;
	logic [2:0] cin, osc, eq;
	logic [3:0] ss;
	logic rclk, co1, co2, co3, oe, lock_o, pass_o, lr_o, eqen, slc, sld;
	logic [6:0] dev;
	logic [31:0] v;
	int failures = 0;
	int n_compared = 0;
	dcr_i2c_host host (.core_clk_in(clk), .sda_oe_in(sda_oe), .scl_out(scl), .sda_out(sda));
	dcr_top dut (.core_clk_in(clk), .rstn_in(rstn), .ce_in(1'b1), .scl_in(scl), .sda_in(sda),
		.sda_out(), .sda_oe_out(sda_oe), .address_strap_pin_in(strap),
		.strap_strobe_edge_select_in(s_edge), .strap_filter_in(s_filt), .strap_low_range_in(s_lr),
		.strap_output_hold_low_in(s_hold), .link_locked_in(lock), .pass_in(pass), .clk_phase_in(phase),
		.data_in(din), .ctrl_in(cin), .recovered_clock_out(rclk), .data_out(dout),
		.control_out_first_out(co1), .control_out_second_out(co2), .control_out_third_out(co3),
		.outputs_oe_out(oe), .link_locked_out(lock_o), .pass_out(pass_o),
		.low_range_spread_select_out(lr_o), .clock_out_slew_boost_out(slc), .data_out_slew_boost_out(sld),
		.internal_oscillator_select_out(osc), .equalizer_gain_step_out(eq),
		.spread_clock_generator_out(ss), .equalizer_enable_out(eqen));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic w(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		logic a0, a1, a2;
		host.start;
		host.wbyte({dev, 1'b0}, a0);
		host.wbyte(p, a1);
		host.wbyte(d, a2);
		host.stop;
		chk({a0, a1, a2}, 32'h7);
		w(4);
	endtask
	// burst read of n bytes from pointer p, newest byte lowest
	task automatic rdn(input logic [7:0] p, input int n, output logic [31:0] r);
		logic a0, a1, a2;
		logic [7:0] b;
		r = 32'h0;
		host.start;
		host.wbyte({dev, 1'b0}, a0);
		host.wbyte(p, a1);
		host.start;
		host.wbyte({dev, 1'b1}, a2);
		for (int i = 0; i < n; i++) begin
			host.rbyte(i == n - 1, b);
			r = {r[23:0], b};
		end
		host.stop;
		chk({a0, a1, a2}, 32'h7);
	endtask
	task automatic conclude;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// ----------------------------------------
	// watchdog: whole run needs well under 40k cycles
	// ----------------------------------------
	initial begin
		#600000;
		failures++;
		conclude;
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		rstn = 1'b0;
		strap = 2'h0;
		s_edge = 1'b0;
		s_filt = 1'b0;
		s_lr = 1'b0;
		s_hold = 1'b0;
		lock = 1'b1;
		pass = 1'b0;
		phase = 1'b1;
		din = 24'ha5c3f0;
		cin = 3'h0;
		dev = 7'h71;
		w(10);
		rstn = 1'b1;
		w(5);
		rdn(8'h00, 4, v);
		chk(v, 32'h00700000);
		chk({dout, rclk, pass_o}, {din, 2'h0});
		s_edge = 1'b1;
		s_lr = 1'b1;
		w(6);
		chk({rclk, lr_o}, 32'h3);
		wr(8'h02, 8'h05);
		chk(osc, 32'h0);
		wr(8'h00, 8'h01);
		chk({rclk, lr_o, osc}, 32'h5);
		wr(8'h00, 8'h91);
		chk({rclk, lr_o}, 32'h3);
		for (int c = 1; c < 8; c++) begin
			wr(8'h02, 8'h30 | c[7:0]);
			chk(osc, c[2:0]);
		end
		rdn(8'h02, 1, v);
		chk(v, 32'h37);
		wr(8'h03, 8'hff);
		chk({eq, ss, eqen}, 32'hff);
		wr(8'h03, 8'h40);
		rdn(8'h03, 1, v);
		chk({v[7:0], eq}, {8'h40, 3'h2});
		// a stranger's address gets no acknowledge
		host.start;
		host.wbyte(8'he4, a);
		host.stop;
		chk(a, 32'h0);
		strap = 2'h1;
		w(6);
		dev = 7'h72;
		wr(8'h01, 8'hf3);
		dev = 7'h73;
		rdn(8'h01, 1, v);
		chk(v, 32'hf3);
		wr(8'h01, 8'h70);
		strap = 2'h3;
		w(6);
		dev = 7'h76;
		rdn(8'h00, 1, v);
		chk(v, 32'h91);
		// sleep keeps registers and parks the outputs
		wr(8'h02, 8'h00);
		wr(8'h00, 8'h73);
		chk({oe, rclk, dout, pass_o, lock_o, slc, sld}, {2'h2, 24'h0, 4'hf});
		wr(8'h02, 8'h40);
		chk(oe, 32'h0);
		wr(8'h00, 8'h11);
		chk({oe, rclk, dout, pass_o, slc, sld}, {2'h3, din, 3'h0});
		rdn(8'h02, 1, v);
		chk(v, 32'h40);
		wr(8'h02, 8'h00);
		s_hold = 1'b1;
		w(6);
		chk({rclk, dout, lock_o}, 32'h1);
		lock = 1'b0;
		w(6);
		chk({rclk, dout, lock_o}, {1'b1, din, 1'b0});
		lock = 1'b1;
		wr(8'h02, 8'h80);
		chk({rclk, dout}, {1'b1, din});
		wr(8'h02, 8'h08);
		chk({rclk, dout}, {1'b1, din});
		// pin mode: override bit has no say, strap keeps hold-low on
		wr(8'h00, 8'h10);
		chk({rclk, dout}, 32'h0);
		s_hold = 1'b0;
		wr(8'h00, 8'h05);
		cin = 3'h7;
		w(2);
		cin = 3'h0;
		w(8);
		chk({co1, co2, co3}, 32'h0);
		cin = 3'h7;
		w(8);
		chk({co1, co2, co3}, 32'h7);
		cin = 3'h0;
		w(8);
		wr(8'h00, 8'h01);
		cin = 3'h7;
		w(2);
		chk({co1, co2, co3}, 32'h7);
		conclude;
	end
endmodule
